// *** design/rcr_params.svh ***
// named constants for the radio channel and signal strength control block
// assumes a 100 MHz core clock and word-indexed 16-bit registers
`ifndef RCR_PARAMS_SVH
`define RCR_PARAMS_SVH

// register indices, byte address is four times the index
`define RCR_IDX_SYNTH      10'h003
`define RCR_IDX_STRENGTH   10'h006
`define RCR_IDX_CHAN_OP    10'h007
`define RCR_IDX_TX_POWER   10'h009
`define RCR_IDX_STR_CTL    10'h00B
`define RCR_IDX_RETRY_CNT  10'h023
`define RCR_IDX_RETRY_CFG  10'h029
`define RCR_IDX_STATUS     10'h030

// field positions
`define RCR_CH_MSB         6
`define RCR_RX_BIT         7
`define RCR_TX_BIT         8
`define RCR_STR_MSB        15
`define RCR_STR_LSB        10
`define RCR_LOCK_BIT       12
`define RCR_STR_OFF_BIT    9
`define RCR_CNT_MSB        11
`define RCR_CNT_LSB        8
`define RCR_RETRY_EN_BIT   11
`define RCR_SYNC_BIT       7

// reset values
`define RCR_RST_CHAN_OP    16'h0000
`define RCR_RST_TX_POWER   16'h1820
`define RCR_RST_STR_CTL    16'h0008
`define RCR_RST_RETRY_CNT  16'h0000
`define RCR_RST_RETRY_CFG  16'h0000

// arithmetic and timing
`define RCR_BASE_MHZ       12'h962
`define RCR_SHORT_PKT_MAX  8'h3F
`define RCR_CLK_NS         10
`define RCR_SETTLE_NS      150000

`endif

// *** design/rcr_pkg.sv ***
// types shared by the channel control block and its retry counter
// assumes rcr_params.svh holds all numeric constants
package rcr_pkg;

    // radio operating mode
    typedef enum logic [1:0] {
        RCR_IDLE,
        RCR_RX,
        RCR_TX
    } rcr_mode_t;

    // complete state of the control block
    typedef struct packed {
        rcr_mode_t   mode;
        logic [8:0]  chan_op;
        logic [6:0]  tune_ch;
        logic [11:0] carrier;
        logic [15:0] tx_power;
        logic [15:0] str_ctl;
        logic [15:0] retry_cnt;
        logic [15:0] retry_cfg;
        logic [5:0]  strength;
        logic [15:0] lock_cnt;
        logic        locked;
        logic        sync_seen;
        logic        pkt_flag;
        logic        fifo_pin;
        logic        dp_valid;
        logic        dp_write;
        logic [9:0]  dp_idx;
        logic [31:0] rdata;
    } rcr_state_t;

    // state of the retry counter
    typedef struct packed {
        logic [3:0] tries;
        logic       retry;
        logic       give_up;
    } rcr_retry_t;

endpackage

// *** design/rcr_retry.sv ***
// automatic retry counter for unacknowledged transmit packets
// assumes start, done and ack are one-cycle pulses, start from a transmit start write, done and ack from the framer
`timescale 1ns/100ps

module rcr_retry (
    // clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    // configuration
    input  wire logic       i_enable,
    input  wire logic [3:0] i_max_tries,
    // framer events
    input  wire logic       i_start,
    input  wire logic       i_tx_done,
    input  wire logic       i_ack_ok,
    // results
    output logic            o_retry,
    output logic            o_give_up,
    output logic [3:0]      o_tries
);
    import rcr_pkg::*;

    rcr_retry_t s;
    rcr_retry_t n;

    // a packet with no ack is resent until the count runs out
    always_comb begin
        n = s;
        n.retry = 1'b0;
        n.give_up = 1'b0;
        if (i_start) begin
            n.tries = 4'h0;
        end else if (i_tx_done && !i_ack_ok) begin
            if (i_enable && (s.tries < i_max_tries)) begin // see R17
                n.tries = s.tries + 4'h1;
                n.retry = 1'b1;
            end else begin
                n.give_up = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign o_retry   = s.retry;
    assign o_give_up = s.give_up;
    assign o_tries   = s.tries;

endmodule

// *** design/rcr_top.sv ***
// channel, operation and signal strength control of a 2.4 GHz radio
// assumes an AHB-Lite master, one 100 MHz clock, framer events as pulses
//
// Behaviour
// R01 - channel number is bits 6 to 0 of the channel register
// R02 - bit 7 starts receive, bit 8 starts transmit
// R03 - carrier in MHz equals 2402 plus channel number
// R04 - channel captured when a start bit is written, held all operation
// R05 - host goes through idle between transmit and receive
// R06 - writing with bits 8 and 7 clear enters idle
// R07 - a new channel may be taken at any time without idle
// R08 - six-bit strength in register 6 bits 15 to 10
// R09 - host reads strength only after receive on and synth settled
// R10 - synth locked flag at register 3 bit 12
// R11 - sync seen flag at register 48 bit 7
// R12 - strength follows any energy, sync or not
// R13 - register 11 bit 9 set disables strength circuit, clear enables
// R14 - host freezes strength, reads it, then re-enables it
// R15 - host selects transmit power through register 9
// R16 - packet pin driven on reception, also readable in register 48
// R17 - unacknowledged packet retried up to count when enabled
// R18 - reset pulse returns every register to default
// R19 - fifo pin matters only for packets longer than 63 bytes
// R20 - packet flag set on sync, held until first byte read
// R21 - host keeps channel numbers in 0 to 78
`timescale 1ns/100ps
`include "rcr_params.svh"

module rcr_top #(
    parameter int unsigned P_SETTLE_CYCLES =
        (`RCR_SETTLE_NS + `RCR_CLK_NS - 1) / `RCR_CLK_NS
) (
    // clock and reset
    input  wire logic              i_clock,
    input  wire logic              i_rst_n,
    // ahb-lite slave
    input  wire logic              i_hsel,
    input  wire logic [31:0]       i_haddr,
    input  wire logic [1:0]        i_htrans,
    input  wire logic              i_hwrite,
    input  wire logic [2:0]        i_hsize,
    input  wire logic [31:0]       i_hwdata,
    input  wire logic              i_hready,
    output logic [31:0]            o_hrdata,
    output logic                   o_hreadyout,
    output logic                   o_hresp,
    // receiver front end
    input  wire logic [5:0]        i_signal_strength,
    input  wire logic              i_sync_detect,
    input  wire logic              i_fifo_first_read,
    input  wire logic [7:0]        i_packet_length,
    input  wire logic              i_fifo_threshold_hit,
    // transmit framer
    input  wire logic              i_tx_done,
    input  wire logic              i_ack_ok,
    // radio control
    output rcr_pkg::rcr_mode_t     o_radio_mode,
    output logic [11:0]            o_carrier_mhz,
    output logic [15:0]            o_tx_power_code,
    output logic                   o_strength_enable,
    output logic                   o_tx_start,
    // packet pins
    output logic                   o_packet_indication_pin,
    output logic                   o_fifo_pin,
    // retry results
    output logic                   o_retry_request,
    output logic                   o_tx_give_up
);
    import rcr_pkg::*;

    rcr_state_t  s;
    rcr_state_t  n;
    logic        rst_meta_n;
    logic        rst_sync_n;
    logic        tune_start;
    logic        tx_start;
    logic        addr_phase;
    logic [15:0] wd;

    // word index from a byte address, upper bits beyond the map ignored
    function automatic logic [9:0] word_index(input logic [31:0] addr);
        word_index = addr[11:2];
    endfunction

    // read image of one register, unmapped words read as zero
    function automatic logic [31:0] read_word(input rcr_state_t st,
                                              input logic [9:0] idx);
        logic [15:0] v;
        v = 16'h0000;
        if (idx == `RCR_IDX_SYNTH) begin
            v[`RCR_LOCK_BIT] = st.locked; // see R10
        end else if (idx == `RCR_IDX_STRENGTH) begin
            v[`RCR_STR_MSB:`RCR_STR_LSB] = st.strength; // see R08
        end else if (idx == `RCR_IDX_CHAN_OP) begin
            v[8:0] = st.chan_op;
        end else if (idx == `RCR_IDX_TX_POWER) begin
            v = st.tx_power;
        end else if (idx == `RCR_IDX_STR_CTL) begin
            v = st.str_ctl;
        end else if (idx == `RCR_IDX_RETRY_CNT) begin
            v = st.retry_cnt;
        end else if (idx == `RCR_IDX_RETRY_CFG) begin
            v = st.retry_cfg;
        end else if (idx == `RCR_IDX_STATUS) begin
            v[`RCR_SYNC_BIT] = st.sync_seen; // see R11, R16
        end else begin
            v = 16'h0000;
        end
        read_word = {16'h0000, v};
    endfunction

    // reset released through two flops so release is clean
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // next state of the whole block
    always_comb begin
        n = s;
        tune_start = 1'b0;
        tx_start = 1'b0;
        wd = i_hwdata[15:0];
        addr_phase = i_hsel && i_htrans[1] && i_hready;

        // data phase of a write, registers hold the low 16 bits
        if (s.dp_valid && s.dp_write) begin
            if (s.dp_idx == `RCR_IDX_CHAN_OP) begin
                n.chan_op = wd[8:0];
                if (wd[`RCR_TX_BIT] || wd[`RCR_RX_BIT]) begin // see R02
                    // any start write retunes, even mid operation
                    n.tune_ch = wd[`RCR_CH_MSB:0]; // see R01, R04, R07
                    tune_start = 1'b1;
                    if (wd[`RCR_TX_BIT]) begin
                        n.mode = RCR_TX;
                        tx_start = 1'b1;
                    end else begin
                        n.mode = RCR_RX;
                    end
                end else begin
                    n.mode = RCR_IDLE; // see R06
                end
            end else if (s.dp_idx == `RCR_IDX_TX_POWER) begin
                n.tx_power = wd;
            end else if (s.dp_idx == `RCR_IDX_STR_CTL) begin
                n.str_ctl = wd;
            end else if (s.dp_idx == `RCR_IDX_RETRY_CNT) begin
                n.retry_cnt = wd;
            end else if (s.dp_idx == `RCR_IDX_RETRY_CFG) begin
                n.retry_cfg = wd;
            end
        end

        // carrier follows the captured channel only
        n.carrier = `RCR_BASE_MHZ + {5'h00, n.tune_ch}; // see R03

        // synthesizer settle model, restarted on every retune
        if (tune_start) begin
            n.lock_cnt = 16'h0000;
            n.locked = 1'b0;
        end else if (s.mode == RCR_IDLE) begin
            n.lock_cnt = 16'h0000;
            n.locked = 1'b0;
        end else if (!s.locked) begin
            if (s.lock_cnt >= 16'(P_SETTLE_CYCLES - 1)) begin
                n.locked = 1'b1; // see R10
            end else begin
                n.lock_cnt = s.lock_cnt + 16'h0001;
            end
        end

        // strength tracks any energy while enabled, frozen otherwise
        if (s.mode == RCR_RX && !s.str_ctl[`RCR_STR_OFF_BIT]) begin
            n.strength = i_signal_strength; // see R12, R13
        end

        // packet flag: clears on a new start or first byte, set wins
        if (tune_start) begin
            n.sync_seen = 1'b0;
            n.pkt_flag = 1'b0;
        end
        if (i_fifo_first_read) begin
            n.pkt_flag = 1'b0;
        end
        if (s.mode == RCR_RX && i_sync_detect) begin
            n.pkt_flag = 1'b1; // see R20
            n.sync_seen = 1'b1; // see R11
        end

        // short packets never need the fifo pin
        n.fifo_pin = i_fifo_threshold_hit &&
                     (i_packet_length > `RCR_SHORT_PKT_MAX); // see R19

        // address phase capture, zero wait states
        n.dp_valid = addr_phase;
        n.dp_write = i_hwrite;
        n.dp_idx = word_index(i_haddr);
        if (addr_phase && !i_hwrite) begin
            // read from next state so a write just before is seen
            n.rdata = read_word(n, word_index(i_haddr));
        end
    end

    // state register, every field back to default on reset
    always_ff @(posedge i_clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin // see R18
            s <= '0;
            s.mode <= RCR_IDLE;
            s.chan_op <= 9'(`RCR_RST_CHAN_OP);  // register keeps bits 8:0
            s.carrier <= `RCR_BASE_MHZ;
            s.tx_power <= `RCR_RST_TX_POWER;
            s.str_ctl <= `RCR_RST_STR_CTL;
            s.retry_cnt <= `RCR_RST_RETRY_CNT;
            s.retry_cfg <= `RCR_RST_RETRY_CFG;
        end else begin
            s <= n;
        end
    end

    // retry counter for the transmit side
    rcr_retry u_retry (
        .i_clock     (i_clock),
        .i_rst_n     (rst_sync_n),
        .i_enable    (s.retry_cfg[`RCR_RETRY_EN_BIT]),
        .i_max_tries (s.retry_cnt[`RCR_CNT_MSB:`RCR_CNT_LSB]),
        .i_start     (tx_start),
        .i_tx_done   (i_tx_done && (s.mode == RCR_TX)),
        .i_ack_ok    (i_ack_ok),
        .o_retry     (o_retry_request),
        .o_give_up   (o_tx_give_up),
        .o_tries     ()
    );

    // bus answers: always ready, always okay
    assign o_hrdata    = s.rdata;
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;

    // radio control outputs
    assign o_radio_mode      = s.mode;
    assign o_carrier_mhz     = s.carrier;
    assign o_tx_power_code   = s.tx_power; // see R15
    assign o_strength_enable = (s.mode == RCR_RX) &&
                               !s.str_ctl[`RCR_STR_OFF_BIT]; // see R13
    assign o_tx_start        = tx_start;

    // packet pins straight from flops
    assign o_packet_indication_pin = s.pkt_flag; // see R16
    assign o_fifo_pin              = s.fifo_pin;

endmodule

// *** testbench/rcr_host_model.sv ***
// host model: single-word ahb-lite master for the control block
// assumes the slave's hreadyout comes back as hready
`timescale 1ns/100ps

module rcr_host_model (
    // answer from the slave
    input  wire logic        i_clock,
    input  wire logic        i_hready,
    input  wire logic [31:0] i_hrdata,
    // request signals
    output logic             o_hsel,
    output logic [31:0]      o_haddr,
    output logic [1:0]       o_htrans,
    output logic             o_hwrite,
    output logic [2:0]       o_hsize,
    output logic [31:0]      o_hwdata
);
    // quiet bus from time zero
    initial begin
        o_hsel   = 1'b0;
        o_haddr  = 32'h0000_0000;
        o_htrans = 2'b00;
        o_hwrite = 1'b0;
        o_hsize  = 3'b010;
        o_hwdata = 32'h0000_0000;
    end

    // bounded wait for hready at a rising edge
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge i_clock);
        while (i_hready !== 1'b1) begin
            n++;
            if (n > 50) begin
                $display("mismatch at %0t: hready timeout", $time);
                tb_radio_channel_and_rssi_control.fail_count++;
                tb_radio_channel_and_rssi_control.tally_and_finish();
            end
            @(posedge i_clock);
        end
    endtask

    // one word transfer, register data in bits 15:0
    task automatic xfer(input logic w, input logic [9:0] idx,
                        input logic [15:0] wd, output logic [15:0] rd);
        o_hsel   <= 1'b1;
        o_htrans <= 2'b10;
        o_haddr  <= {20'h0_0000, idx, 2'b00};
        o_hwrite <= w;
        wait_ready();
        o_hsel   <= 1'b0;
        o_htrans <= 2'b00;
        o_hwdata <= {16'h0000, wd};
        wait_ready();
        rd = i_hrdata[15:0];
        o_hwdata <= ~o_hwdata;  // stale data must not look valid
        #1;
    endtask
endmodule

// *** testbench/rcr_top_assertions.sv ***
// port-level checks of the channel, strength and packet pin control
// assumes one clock, bound to rcr_top, host waits out the reset lag
`timescale 1ns/100ps
`include "rcr_params.svh"

module rcr_top_checker (
    // clock, reset and bus
    input wire logic        i_clock,
    input wire logic        i_rst_n,
    input wire logic        i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0]  i_htrans,
    input wire logic        i_hwrite,
    input wire logic [31:0] i_hwdata,
    input wire logic        i_hready,
    // front end, framer and outputs
    input wire logic        i_sync_detect,
    input wire logic [7:0]  i_packet_length,
    input wire logic        i_fifo_threshold_hit,
    input wire logic        i_tx_done,
    input wire logic        i_ack_ok,
    input wire rcr_pkg::rcr_mode_t o_radio_mode,
    input wire logic [11:0] o_carrier_mhz,
    input wire logic        o_strength_enable,
    input wire logic        o_tx_start,
    input wire logic        o_packet_indication_pin,
    input wire logic        o_fifo_pin,
    input wire logic        o_retry_request,
    input wire logic        o_tx_give_up
);
    import rcr_pkg::*;
    logic [2:0] live;  // edges since release, design lags by two
    logic       wr7;   // channel register write now in data phase
    logic       wr11;  // strength control write now in data phase
    logic       str_off; // off bit as last written to register 11

    // helper state, cleared with the reset pin
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            live <= 3'b000;
            wr7  <= 1'b0;
            wr11 <= 1'b0;
            str_off <= 1'b0;  // register 11 resets with the off bit clear
        end else begin
            live <= {live[1:0], 1'b1};
            wr7  <= live[1] && i_hsel && i_htrans[1] && i_hready && i_hwrite
                    && i_haddr[11:2] == `RCR_IDX_CHAN_OP;
            wr11 <= live[1] && i_hsel && i_htrans[1] && i_hready && i_hwrite
                    && i_haddr[11:2] == `RCR_IDX_STR_CTL;
            // mirror lands on the data edge, as the register does
            if (wr11) begin
                str_off <= i_hwdata[`RCR_STR_OFF_BIT];
            end
        end
    end

    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    a_carrier_set: assert property (wr7
        && i_hwdata[8:7] != 2'b00
        |=> o_carrier_mhz == `RCR_BASE_MHZ + 12'($past(i_hwdata[6:0])))
        else $error("carrier not tuned to written channel");
    a_tx_start: assert property (wr7 && i_hwdata[8]
        |-> o_tx_start ##1 o_radio_mode == RCR_TX) else $error("no tx start");
    a_idle_write: assert property (wr7 && i_hwdata[8:7] == 2'b00
        |=> o_radio_mode == RCR_IDLE) else $error("idle write ignored");
    a_carrier_hold: assert property (live[2] && !wr7
        |=> $stable(o_carrier_mhz)) else $error("carrier moved mid run");
    a_strength_rx: assert property (live[2]
        |-> o_strength_enable == (o_radio_mode == RCR_RX && !str_off))
        else $error("strength enable wrong for mode or control");
    a_pin_cause: assert property ($rose(o_packet_indication_pin)
        |-> $past(i_sync_detect)) else $error("packet pin without sync");
    a_fifo_pin: assert property (live[2] |-> o_fifo_pin ==
        $past(i_fifo_threshold_hit && i_packet_length > `RCR_SHORT_PKT_MAX))
        else $error("fifo pin wrong for length");
    a_nack_answer: assert property (live[2] && i_tx_done
        && !i_ack_ok
        && o_radio_mode == RCR_TX |=> o_retry_request != o_tx_give_up)
        else $error("no retry or give up on nack");
    a_ack_quiet: assert property (i_tx_done && i_ack_ok
        |=> !o_retry_request && !o_tx_give_up) else $error("retry on ack");
endmodule

bind rcr_top rcr_top_checker u_checker (.i_clock, .i_rst_n, .i_hsel,
    .i_haddr, .i_htrans, .i_hwrite, .i_hwdata, .i_hready, .i_sync_detect,
    .i_packet_length, .i_fifo_threshold_hit, .i_tx_done, .i_ack_ok,
    .o_radio_mode, .o_carrier_mhz, .o_strength_enable, .o_tx_start,
    .o_packet_indication_pin, .o_fifo_pin, .o_retry_request, .o_tx_give_up);

// *** testbench/tb_radio_channel_and_rssi_control.sv ***
// self-checking bench for the channel and strength control block
// assumes rcr_host_model drives the bus, the checker is bound
`timescale 1ns/100ps
`include "rcr_params.svh"

module tb_radio_channel_and_rssi_control;
    import rcr_pkg::*;
    localparam logic [9:0] CHOP = `RCR_IDX_CHAN_OP;
    // stimulus, driven on the rising edge
    logic        clk = 1'b0, rst_n = 1'b0, sync = 1'b0, first_rd = 1'b0;
    logic        thr_hit = 1'b0, tx_done = 1'b0, ack_ok = 1'b0;
    logic [5:0]  strength = 6'h00;
    logic [7:0]  pkt_len = 8'h00;
    // bus wires and observed outputs
    logic        hsel, hwrite, hready, str_en, pkt_pin, fifo_pin;
    logic        retry, give_up, hresp;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [11:0] carrier;
    logic [15:0] power, rv;
    logic [31:0] haddr, hwdata, hrdata;
    rcr_mode_t   mode;
    int          fail_count = 0, n_tests = 0, n_retry = 0, n_give = 0;

    // 100 MHz clock
    always #5 clk = ~clk;
    // pulse counters for the retry outputs
    always @(posedge clk) begin
        n_retry <= n_retry + int'(retry === 1'b1);
        n_give  <= n_give + int'(give_up === 1'b1);
    end

    // host and block under test, settle count cut to 8
    rcr_host_model host (.i_clock(clk), .i_hready(hready), .i_hrdata(hrdata),
        .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans),
        .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata));
    rcr_top #(.P_SETTLE_CYCLES(8)) uut (.i_clock(clk), .i_rst_n(rst_n),
        .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
        .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_signal_strength(strength), .i_sync_detect(sync),
        .i_fifo_first_read(first_rd), .i_packet_length(pkt_len),
        .i_fifo_threshold_hit(thr_hit), .i_tx_done(tx_done),
        .i_ack_ok(ack_ok), .o_radio_mode(mode), .o_carrier_mhz(carrier),
        .o_tx_power_code(power), .o_strength_enable(str_en), .o_tx_start(),
        .o_packet_indication_pin(pkt_pin), .o_fifo_pin(fifo_pin),
        .o_retry_request(retry), .o_tx_give_up(give_up));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [9:0] idx, input logic [15:0] d);
        host.xfer(1'b1, idx, d, rv);
    endtask
    task automatic rd(input logic [9:0] idx);
        host.xfer(1'b0, idx, 16'h0000, rv);
    endtask

    // register defaults, last index is unmapped
    task automatic t_reset();
        logic [9:0]  ix [6] = '{`RCR_IDX_TX_POWER, `RCR_IDX_STR_CTL, CHOP,
            `RCR_IDX_RETRY_CNT, `RCR_IDX_RETRY_CFG, 10'h3FF};
        logic [15:0] ex [6] = '{`RCR_RST_TX_POWER, `RCR_RST_STR_CTL,
            16'h0000, 16'h0000, 16'h0000, 16'h0000};
        chk(16'(carrier), 16'h0962);
        chk(16'(hresp), 16'h0000);
        for (int i = 0; i < 6; i++) begin
            rd(ix[i]);
            chk(rv, ex[i]);
        end
        $display("t_reset done");
    endtask

    // table channels in receive and transmit, idle in between
    task automatic t_chan();
        logic [6:0]  ch [6] = '{7'h00, 7'h01, 7'h02, 7'h20, 7'h27, 7'h4E};
        logic [15:0] v;
        for (int i = 0; i < 6; i++) begin
            for (int t = 0; t < 2; t++) begin
                v = {7'h00, t[0], !t[0], ch[i]};
                wr(CHOP, v);
                chk(16'(carrier), 16'(12'h962 + ch[i]));
                chk(16'(mode), t[0] ? 16'(RCR_TX) : 16'(RCR_RX));
                rd(CHOP);
                chk(rv, v);
                wr(CHOP, {9'h000, ch[i]});
                chk(16'(mode), 16'(RCR_IDLE));
            end
        end
        $display("t_chan done");
    endtask

    // direct channel jump, then an idle write must not retune
    task automatic t_jump();
        wr(CHOP, 16'h0085);
        wr(CHOP, 16'h0089);
        chk(16'(carrier), 16'h096B);
        wr(CHOP, 16'h0032);
        chk(16'(carrier), 16'h096B);
        $display("t_jump done");
    endtask

    // lock flag, live strength without sync, freeze and release
    task automatic t_rssi();
        wr(CHOP, 16'h0094);
        rd(`RCR_IDX_SYNTH);
        chk(16'(rv[12]), 16'h0000);
        tick(8);
        rd(`RCR_IDX_SYNTH);
        chk(16'(rv[12]), 16'h0001);
        @(posedge clk) strength <= 6'h2A;
        tick(2);
        rd(`RCR_IDX_STRENGTH);
        chk(16'(rv[15:10]), 16'h002A);
        wr(`RCR_IDX_STR_CTL, 16'h0208);
        chk(16'(str_en), 16'h0000);
        @(posedge clk) strength <= 6'h15;
        tick(2);
        rd(`RCR_IDX_STRENGTH);
        chk(16'(rv[15:10]), 16'h002A);
        wr(`RCR_IDX_STR_CTL, 16'h0008);
        tick(2);
        rd(`RCR_IDX_STRENGTH);
        chk(16'(rv[15:10]), 16'h0015);
        $display("t_rssi done");
    endtask

    // packet pin held until first byte read, fifo pin above 63 bytes
    task automatic t_pins();
        @(posedge clk) sync <= 1'b1;
        @(posedge clk) sync <= 1'b0;
        tick(5);
        chk(16'(pkt_pin), 16'h0001);
        rd(`RCR_IDX_STATUS);
        chk(16'(rv[7]), 16'h0001);
        @(posedge clk) first_rd <= 1'b1;
        @(posedge clk) first_rd <= 1'b0;
        tick(1);
        chk(16'(pkt_pin), 16'h0000);
        @(posedge clk) thr_hit <= 1'b1;
        pkt_len <= 8'h3F;
        tick(2);
        chk(16'(fifo_pin), 16'h0000);
        @(posedge clk) pkt_len <= 8'h40;
        tick(2);
        chk(16'(fifo_pin), 16'h0001);
        @(posedge clk) thr_hit <= 1'b0;
        $display("t_pins done");
    endtask

    // power code, then three nacks with count 2 and one ack
    task automatic t_retry();
        int r0, g0;
        wr(`RCR_IDX_TX_POWER, 16'h1E20);
        chk(power, 16'h1E20);
        wr(`RCR_IDX_RETRY_CNT, 16'h0200);
        wr(`RCR_IDX_RETRY_CFG, 16'h0800);
        wr(CHOP, 16'h0000);
        wr(CHOP, 16'h0100);
        r0 = n_retry;
        g0 = n_give;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk) tx_done <= 1'b1;
            ack_ok <= 1'(k == 3);
            @(posedge clk) tx_done <= 1'b0;
            tick(3);
        end
        chk(16'(n_retry - r0), 16'h0002);
        chk(16'(n_give - g0), 16'h0001);
        $display("t_retry done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // reset held for 12 cycles, then the scenarios in order
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        tick(3);
        t_reset();
        t_chan();
        t_jump();
        t_rssi();
        t_pins();
        t_retry();
        tally_and_finish();
    end
endmodule
